// ### verilog/lcd_bias_ctrl.sv
// lcd bias ladder power, reference, contrast and backplane selection control
//
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module lcd_bias_ctrl
    import lcd_bias_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic tick32_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [1:0] ladder_power_out,
    output logic half_bias_out,
    output logic contrast_enable_out,
    output logic [2:0] contrast_tap_out,
    output logic ref_enable_out,
    output logic ref_buffer_enable_out,
    output logic fvr_request_out,
    output logic [2:0] bias_pin_enable_out,
    output logic [3:0] backplane_active_out,
    output logic [3:0] backplane_oe_out,
    output logic phase_out,
    output logic display_active_out,
    output logic interval_a_out
);

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    ladder_cfg_t ladder_cfg;
    ref_cfg_t ref_cfg;
    logic display_enable;
    logic waveform_type_bit;
    logic half_bias_select;
    logic [1:0] backplane_count_select;
    logic [2:0] contrast_select;
    logic [3:0] pin_direction_bit;
    display_state_t state;
    display_state_t next_state;
    logic phase;

    // ------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ------------------------------------------------------------
    logic bus_req;
    logic bus_ack;
    logic wr_take;
    logic lane0;
    logic hit_ladder;
    logic hit_display;
    logic hit_ref;
    logic hit_contrast;
    logic hit_dir;
    logic hit_status;
    logic [7:0] rd_mux;
    logic display_active_flag;
    logic interval_a;
    ladder_power_t eff_power;

    assign bus_req = avs_read_in || avs_write_in;
    // ack is the inverse of the registered waitrequest
    assign bus_ack = !avs_waitrequest_out;
    assign lane0 = avs_byteenable_in[0];
    assign wr_take = avs_write_in && bus_ack && lane0;
    assign hit_ladder = avs_address_in == OFS_LADDER_POWER;
    assign hit_display = avs_address_in == OFS_DISPLAY_CTRL;
    assign hit_ref = avs_address_in == OFS_BIAS_REF;
    assign hit_contrast = avs_address_in == OFS_CONTRAST;
    assign hit_dir = avs_address_in == OFS_PIN_DIR;
    assign hit_status = avs_address_in == OFS_STATUS;
    assign display_active_flag = state != ST_IDLE;

    // unmapped offsets and bit 3 of the ladder register read as zero
    assign rd_mux = hit_ladder ? {ladder_cfg[6:3], 1'b0, ladder_cfg[2:0]} :
                    hit_display ? {display_enable, display_active_flag, waveform_type_bit,
                                   half_bias_select, 2'h0, backplane_count_select} :
                    hit_ref ? {ref_cfg[5:3], 1'b0, ref_cfg[2:0], 1'b0} :
                    hit_contrast ? {5'h00, contrast_select} :
                    hit_dir ? {4'h0, pin_direction_bit} :
                    hit_status ? {5'h00, eff_power, interval_a} : 8'h00;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
            avs_readdata_out <= {24'h00_0000, rd_mux};
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ladder_cfg <= {RST_LADDER_POWER[7:4], RST_LADDER_POWER[2:0]};
            {display_enable, waveform_type_bit, half_bias_select} <= 3'h0;
            backplane_count_select <= RST_DISPLAY_CTRL[1:0];
            ref_cfg <= {RST_BIAS_REF[7:5], RST_BIAS_REF[3:1]};
            contrast_select <= RST_CONTRAST;
            pin_direction_bit <= RST_PIN_DIR;
        end else if (ce_in && wr_take) begin
            if (hit_ladder) begin
                ladder_cfg <= {avs_writedata_in[7:4], avs_writedata_in[2:0]};
            end
            if (hit_display) begin
                display_enable <= avs_writedata_in[DC_ENABLE_BIT];
                waveform_type_bit <= avs_writedata_in[DC_WAVE_BIT];
                half_bias_select <= avs_writedata_in[DC_HALF_BIAS_BIT];
                backplane_count_select <= avs_writedata_in[DC_MUX_LSB +: 2];
            end
            if (hit_ref) begin
                ref_cfg <= {avs_writedata_in[7:5], avs_writedata_in[BR_PIN_EN_LSB +: 3]};
            end
            if (hit_contrast) begin
                contrast_select <= avs_writedata_in[2:0];
            end
            if (hit_dir) begin
                pin_direction_bit <= avs_writedata_in[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler, transitions and backplane slots
    // ------------------------------------------------------------
    logic [4:0] prescale;
    logic slot_wrap;
    logic [1:0] slot;
    logic frame_end;
    logic transition;
    logic [4:0] ab_pos;
    logic hold_clear;

    assign hold_clear = !display_active_flag;

    // the 5-bit prescaler that yields the base rate also times A and B
    wrap_counter #(.WIDTH(5)) prescaler_u (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .clear_in(hold_clear),
        .step_in(tick32_in),
        .limit_in(PRESCALE_LAST),
        .count_out(prescale),
        .wrap_out(slot_wrap)
    );

    wrap_counter #(.WIDTH(2)) slot_u (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .clear_in(hold_clear),
        .step_in(slot_wrap),
        .limit_in(backplane_count_select),
        .count_out(slot),
        .wrap_out(frame_end)
    );

    // type A changes level mid-slot, so its intervals are 16 ticks long
    assign transition = waveform_type_bit ? slot_wrap
                        : tick32_in && (prescale[3:0] == HALF_SLOT_LAST);
    // position restarts at every transition since it is the low prescaler bits
    assign ab_pos = waveform_type_bit ? prescale : {1'b0, prescale[3:0]};
    // duration 0 never satisfies the compare, so B power holds throughout
    assign interval_a = display_active_flag
                        && (ab_pos < {2'b00, ladder_cfg.duration});

    // ------------------------------------------------------------
    // active flag: off only at a frame boundary
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (display_enable) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!display_enable) begin
                    next_state = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                // glass must see whole frames to avoid a dc residue
                if (frame_end) begin
                    next_state = ST_IDLE;
                end else if (display_enable) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= ST_IDLE;
            phase <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            if (hold_clear) begin
                phase <= 1'b0;
            end else if (waveform_type_bit ? frame_end : transition) begin
                phase <= !phase;
            end
        end
    end

    // ------------------------------------------------------------
    // analog control decode
    // ------------------------------------------------------------
    logic ref_on;
    logic next_buffer;
    logic [3:0] line_used;
    logic [3:0] next_oe;

    assign eff_power = !display_active_flag ? POWER_OFF :
                       interval_a ? ladder_cfg.a_power :
                       ladder_cfg.b_power;
    assign ref_on = display_active_flag && ref_cfg.int_ref;
    assign next_buffer = ref_on && ref_cfg.fvr_sel
                         && !(ref_cfg.auto_off && !interval_a);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            assign line_used[gi] = gi <= backplane_count_select;
            // a driven backplane overrides the pin's own direction setting
            assign next_oe[gi] = line_used[gi] || !pin_direction_bit[gi];
        end
    endgenerate

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ladder_power_out <= POWER_OFF;
            half_bias_out <= 1'b0;
            contrast_enable_out <= 1'b0;
            contrast_tap_out <= RST_CONTRAST;
            ref_enable_out <= 1'b0;
            ref_buffer_enable_out <= 1'b0;
            fvr_request_out <= 1'b0;
            bias_pin_enable_out <= 3'h0;
            backplane_active_out <= 4'h0;
            backplane_oe_out <= 4'h0;
            phase_out <= 1'b0;
            display_active_out <= 1'b0;
            interval_a_out <= 1'b0;
        end else if (ce_in) begin
            ladder_power_out <= eff_power;
            half_bias_out <= half_bias_select;
            contrast_enable_out <= ref_on;
            contrast_tap_out <= contrast_select;
            ref_enable_out <= ref_on;
            ref_buffer_enable_out <= next_buffer;
            fvr_request_out <= ref_on && ref_cfg.fvr_sel;
            bias_pin_enable_out <= ref_cfg.pin_en;
            backplane_active_out <= line_used;
            backplane_oe_out <= next_oe;
            phase_out <= phase;
            display_active_out <= display_active_flag;
            interval_a_out <= interval_a;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_b_in);

    ladder_off_inactive_a: assert property (
        ce_in && !display_active_flag |=> ladder_power_out == POWER_OFF)
        else $error("ladder powered while display inactive");

    ladder_power_sel_a: assert property (
        ce_in && display_active_flag |=> ladder_power_out
            == ($past(interval_a) ? $past(ladder_cfg.a_power) : $past(ladder_cfg.b_power)))
        else $error("ladder power does not follow interval setting");

    contrast_gate_a: assert property (
        ce_in && (!display_active_flag || !ref_cfg.int_ref) |=> !contrast_enable_out)
        else $error("contrast enabled without active internal reference");

    ref_off_inactive_a: assert property (
        ce_in && !display_active_flag |=> !ref_enable_out && !fvr_request_out)
        else $error("reference on while display inactive");

    buffer_auto_off_a: assert property (
        ce_in && ref_on && ref_cfg.fvr_sel && ref_cfg.auto_off && !interval_a
            |=> !ref_buffer_enable_out)
        else $error("reference buffer left on in interval b");

    zero_duration_a: assert property (
        ce_in && ladder_cfg.duration == 3'h0 |=> !interval_a_out)
        else $error("interval a seen with zero duration");

    a_starts_transition_a: assert property (
        $rose(interval_a) && $past(display_active_flag) && $stable(ladder_cfg)
            && $stable(waveform_type_bit) |-> ab_pos == 5'h00)
        else $error("interval a did not begin at a transition");

    type_a_period_a: assert property (
        !waveform_type_bit && display_active_flag && prescale == 5'h10
            && ladder_cfg.duration != 3'h0 |-> interval_a)
        else $error("type a interval a missing in second half slot");

    shutdown_frame_a: assert property (
        ce_in && state == ST_STOPPING && !frame_end |=> display_active_flag)
        else $error("active flag dropped before frame end");

    backplane_static_a: assert property (
        ce_in && backplane_count_select == 2'h0 |=> backplane_active_out == 4'h1)
        else $error("static drive must use only line zero");

    dir_override_a: assert property (
        ce_in && line_used[3] |=> backplane_oe_out[3])
        else $error("active backplane not driven");

    shutdown_seen_c: cover property (state == ST_STOPPING ##1 state == ST_IDLE);
    type_b_interval_c: cover property (waveform_type_bit && $fell(interval_a));
    buffer_drop_c: cover property ($fell(ref_buffer_enable_out) && ref_enable_out);

endmodule : lcd_bias_ctrl

// ### verilog/lcd_bias_pkg.sv
// constants, register map and types for the lcd bias ladder control block
package lcd_bias_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_LADDER_POWER = 5'h00;
    localparam logic [4:0] OFS_DISPLAY_CTRL = 5'h04;
    localparam logic [4:0] OFS_BIAS_REF = 5'h08;
    localparam logic [4:0] OFS_CONTRAST = 5'h0C;
    localparam logic [4:0] OFS_PIN_DIR = 5'h10;
    localparam logic [4:0] OFS_STATUS = 5'h14;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_LADDER_POWER = 8'h00;
    localparam logic [7:0] RST_DISPLAY_CTRL = 8'h00;
    localparam logic [7:0] RST_BIAS_REF = 8'h00;
    localparam logic [2:0] RST_CONTRAST = 3'h0;
    localparam logic [3:0] RST_PIN_DIR = 4'hF;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LP_A_POWER_LSB = 6;
    localparam int LP_B_POWER_LSB = 4;
    localparam int LP_DURATION_LSB = 0;
    localparam int DC_ENABLE_BIT = 7;
    localparam int DC_ACTIVE_BIT = 6;
    localparam int DC_WAVE_BIT = 5;
    localparam int DC_HALF_BIAS_BIT = 4;
    localparam int DC_MUX_LSB = 0;
    localparam int BR_INT_REF_BIT = 7;
    localparam int BR_FVR_SEL_BIT = 6;
    localparam int BR_AUTO_OFF_BIT = 5;
    localparam int BR_PIN_EN_LSB = 1;

    // ------------------------------------------------------------
    // timing in 32 kHz ticks
    // ------------------------------------------------------------
    localparam logic [4:0] PRESCALE_LAST = 5'h1F;
    localparam logic [3:0] HALF_SLOT_LAST = 4'hF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        POWER_OFF = 2'h0,
        POWER_LOW = 2'h1,
        POWER_MEDIUM = 2'h2,
        POWER_HIGH = 2'h3
    } ladder_power_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_STOPPING = 2'h3
    } display_state_t;

    typedef struct packed {
        ladder_power_t a_power;
        ladder_power_t b_power;
        logic [2:0] duration;
    } ladder_cfg_t;

    typedef struct packed {
        logic int_ref;
        logic fvr_sel;
        logic auto_off;
        logic [2:0] pin_en;
    } ref_cfg_t;

endpackage : lcd_bias_pkg

// ### verilog/wrap_counter.sv
// wrapping tick counter with clear, used for prescaler and backplane slots
`timescale 1ns/1ps
module wrap_counter
    import lcd_bias_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic [WIDTH-1:0] limit_in,
    output logic [WIDTH-1:0] count_out,
    output logic wrap_out
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    assign wrap_out = step_in && (count == limit_in);
    assign next_count = clear_in ? '0 :
                        wrap_out ? '0 :
                        step_in ? count + 1'b1 : count;
    assign count_out = count;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= '0;
        end else if (ce_in) begin
            count <= next_count;
        end
    end

endmodule : wrap_counter

// ### sim/lcd_glass_model.sv
// behavioural glass and external bias network seen from the driver pins
`timescale 1ns/1ps
module lcd_glass_model (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic phase_in,
    input wire logic [1:0] ladder_power_in,
    output logic [15:0] toggles_out,
    output logic ext_bias_needed_out
);
    // ----------------------------------------
    // phase reversals seen on the glass
    // ----------------------------------------
    logic last_phase;
    // glass is a capacitor: it only notes reversals, it never answers
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_phase <= 1'b0;
            toggles_out <= 16'h0000;
        end else begin
            last_phase <= phase_in;
            if (phase_in != last_phase) begin
                toggles_out <= toggles_out + 16'h0001;
            end
        end
    end
    // a disconnected ladder leaves the bias nodes to the outside network
    assign ext_bias_needed_out = (ladder_power_in == 2'h0);
endmodule : lcd_glass_model

// ### sim/lcd_bias_ctrl_tb.sv
// self-checking bench for the lcd bias ladder control block
`timescale 1ns/1ps
module lcd_bias_ctrl_tb;
    import lcd_bias_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ce_in = 1'b1;
    logic tick32 = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic waitreq;
    logic [1:0] power;
    logic half, con_en, ref_en, buf_en, fvr_req, phase, active, ia;
    logic [2:0] tap, pin_en;
    logic [3:0] bp_act, bp_oe;
    logic [15:0] toggles;
    logic ext_bias;
    int n_fail = 0;
    int checks = 0;
    int tcnt = 0;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h000102AF;

    initial begin
        forever #50 mclk_in = ~mclk_in;
    end
    // tick every 8 cycles keeps the run short; the block only counts pulses
    always @(posedge mclk_in) begin
        tcnt <= (tcnt + 1) % 8;
        tick32 <= (tcnt == 6);
    end

    lcd_bias_ctrl lcd_bias_ctrl_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
        .tick32_in(tick32), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .ladder_power_out(power), .half_bias_out(half),
        .contrast_enable_out(con_en), .contrast_tap_out(tap), .ref_enable_out(ref_en),
        .ref_buffer_enable_out(buf_en), .fvr_request_out(fvr_req),
        .bias_pin_enable_out(pin_en), .backplane_active_out(bp_act),
        .backplane_oe_out(bp_oe), .phase_out(phase), .display_active_out(active),
        .interval_a_out(ia));
    lcd_glass_model lcd_glass_model_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
        .phase_in(phase), .ladder_power_in(power), .toggles_out(toggles),
        .ext_bias_needed_out(ext_bias));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic final_report();
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // one avalon transfer: hold everything until waitrequest is sampled low
    // no local limit: only the watchdog ends a wait
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] b);
        @(posedge mclk_in);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h000000, d};
        be <= b;
        do begin
            @(posedge mclk_in);
        end while (waitreq !== 1'b0);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    task automatic rd_exp(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(1'b0, a, 8'h00, 4'hF);
    endtask : rd_exp

    // read data are taken at the edge where waitrequest is seen low
    always @(posedge mclk_in) begin
        if (rd === 1'b1 && waitreq === 1'b0) begin
            if (exp_q.size() > 0) chk("readdata", exp_q.pop_front(), rdata);
            else chk("readdata unexpected", 32'h0, 32'h1);
        end
    end

    // measure A/B sharing over 64 base ticks for one setting
    task automatic meas(input logic w, input logic [1:0] a, input logic [1:0] b,
                        input logic [2:0] n);
        int hi;
        logic [15:0] t0;
        bus(1'b1, OFS_LADDER_POWER, {a, b, 1'b0, n}, 4'hF);
        bus(1'b1, OFS_DISPLAY_CTRL, {2'b10, w, 5'h00}, 4'hF);
        repeat (40 * 8) @(posedge mclk_in);
        t0 = toggles;
        hi = 0;
        repeat (64) begin
            repeat (8) @(posedge mclk_in);
            if (ia === 1'b1) hi++;
            chk("ladder power", {30'h0, (ia === 1'b1) ? a : b}, {30'h0, power});
            chk("buffer", {31'h0, ia}, {31'h0, buf_en});
        end
        chk("interval A ticks", w ? 2 * n : 4 * n, hi);
        chk("phase toggles", w ? 32'd2 : 32'd4, {16'h0, toggles - t0});
    endtask : meas

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [3:0] act;
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        // reset values, then an unmapped word
        rd_exp(OFS_LADDER_POWER, RST_LADDER_POWER);
        rd_exp(OFS_DISPLAY_CTRL, RST_DISPLAY_CTRL);
        rd_exp(OFS_BIAS_REF, RST_BIAS_REF);
        rd_exp(OFS_CONTRAST, {5'h00, RST_CONTRAST});
        rd_exp(OFS_PIN_DIR, {4'h0, RST_PIN_DIR});
        rd_exp(5'h18, 8'h00);
        bus(1'b1, OFS_LADDER_POWER, 8'hFF, 4'hF);
        rd_exp(OFS_LADDER_POWER, 8'hF7);
        bus(1'b1, OFS_CONTRAST, 8'h07, 4'h0);
        rd_exp(OFS_CONTRAST, 8'h00);
        bus(1'b1, OFS_CONTRAST, 8'h07, 4'hF);
        bus(1'b1, OFS_DISPLAY_CTRL, 8'h53, 4'hF);
        rd_exp(OFS_DISPLAY_CTRL, 8'h13);
        repeat (3) @(posedge mclk_in);
        chk("half bias", 32'h1, {31'h0, half});
        chk("tap", 32'h7, {29'h0, tap});
        chk("inactive power", 32'h0, {30'h0, power});
        chk("inactive contrast", 32'h0, {31'h0, con_en});
        // backplane lines for every count, pin direction 0101
        bus(1'b1, OFS_PIN_DIR, 8'h05, 4'hF);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, OFS_DISPLAY_CTRL, 8'h00 | m[1:0], 4'hF);
            repeat (3) @(posedge mclk_in);
            act = 4'((16'h1 << (m + 1)) - 16'h1);
            chk("backplane active", {28'h0, act}, {28'h0, bp_act});
            chk("backplane oe", {28'h0, act | 4'hA}, {28'h0, bp_oe});
        end
        // internal reference off: contrast off, no reference request
        bus(1'b1, OFS_BIAS_REF, 8'h4A, 4'hF);
        bus(1'b1, OFS_DISPLAY_CTRL, 8'h80, 4'hF);
        repeat (3) @(posedge mclk_in);
        chk("no ref contrast", 32'h0, {31'h0, con_en});
        chk("no ref request", 32'h0, {31'h0, fvr_req});
        chk("pin enables", 32'h5, {29'h0, pin_en});
        bus(1'b1, OFS_BIAS_REF, 8'hEA, 4'hF);
        repeat (3) @(posedge mclk_in);
        chk("ref on", 32'h1, {31'h0, ref_en});
        chk("ref request", 32'h1, {31'h0, fvr_req});
        chk("contrast on", 32'h1, {31'h0, con_en});
        rd_exp(OFS_BIAS_REF, 8'hEA);
        // A/B switching: every power code, both waveforms, boundary durations
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            meas(i[0], (i < 4) ? i[1:0] : r[7:6], (i < 4) ? ~i[1:0] : r[5:4],
                 (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : r[2:0]);
        end
        // clock enable low: every flop holds, ticks are ignored
        ce_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        r = {28'h0, phase, ia, power};
        repeat (200) @(posedge mclk_in);
        chk("frozen outputs", r, {28'h0, phase, ia, power});
        ce_in <= 1'b1;
        // disable: the frame runs out before the flag drops
        bus(1'b1, OFS_DISPLAY_CTRL, 8'h02, 4'hF);
        repeat (3) @(posedge mclk_in);
        chk("still active", 32'h1, {31'h0, active});
        for (int n = 0; n < 3000 && active !== 1'b0; n++) @(posedge mclk_in);
        repeat (3) @(posedge mclk_in);
        chk("flag cleared", 32'h0, {31'h0, active});
        chk("ladder off", 32'h0, {30'h0, power});
        chk("glass external", 32'h1, {31'h0, ext_bias});
        chk("ref off", 32'h0, {31'h0, ref_en});
        chk("contrast open", 32'h0, {31'h0, con_en});
        rd_exp(OFS_DISPLAY_CTRL, 8'h02);
        rd_exp(OFS_STATUS, 8'h00);
        repeat (4) @(posedge mclk_in);
        chk("reads pending", 32'h0, exp_q.size());
        final_report();
    end

    // watchdog: the sequence needs well under 15000 cycles
    initial begin
        repeat (40000) @(posedge mclk_in);
        n_fail++;
        final_report();
    end
endmodule : lcd_bias_ctrl_tb
